/* rtl/dpc_pkg.sv */
package dpc_pkg;
    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned OUT_W        = 20;
    localparam int unsigned PAT_W        = 20;
    // register indices; byte address is four times the index
    localparam logic [5:0]  IDX_PAT_LOW  = 6'h20;
    localparam logic [5:0]  IDX_PAT_MID  = 6'h21;
    localparam logic [5:0]  IDX_PAT_HIGH = 6'h22;
    localparam logic [5:0]  IDX_DSP_CTL  = 6'h24;
    localparam logic [5:0]  IDX_DEC_CTL  = 6'h25;
    localparam logic [5:0]  IDX_GAIN     = 6'h26;
    // reset values
    localparam logic [7:0]  RST_PAT_LOW  = 8'h00;
    localparam logic [7:0]  RST_PAT_MID  = 8'hfc;
    localparam logic [7:0]  RST_PAT_HIGH = 8'h0f;
    localparam logic [7:0]  RST_DSP_CTL  = 8'h00;
    localparam logic [7:0]  RST_DEC_CTL  = 8'h00;
    localparam logic [7:0]  RST_GAIN     = 8'h00;
    // writable bit masks; all other bits are reserved
    localparam logic [7:0]  MSK_PAT_HIGH = 8'h4f;
    localparam logic [7:0]  MSK_DSP_CTL  = 8'h3e;
    localparam logic [7:0]  MSK_DEC_CTL  = 8'hf8;
    localparam logic [7:0]  MSK_GAIN     = 8'hee;
    // field positions
    localparam int unsigned POS_SCRAMBLE = 6;
    localparam int unsigned POS_AVERAGE  = 5;
    localparam int unsigned POS_INP_SEL  = 3;
    localparam int unsigned POS_DSP_EN   = 2;
    localparam int unsigned POS_DC_EN    = 1;
    localparam int unsigned POS_MUX_EN   = 7;
    localparam int unsigned POS_DEC_RAT  = 4;
    localparam int unsigned POS_REAL     = 3;
    localparam int unsigned POS_GAIN0    = 6;
    localparam int unsigned POS_OSC0_RST = 5;
    localparam int unsigned POS_GAIN1    = 2;
    localparam int unsigned POS_OSC1_RST = 1;
    localparam logic [1:0]  GAIN_6DB     = 2'h2;
    localparam logic [2:0]  DEC_MAX_CODE = 3'h5;
    localparam logic [14:0] SCR_SEED     = 15'h7fff;

    typedef struct packed {
        logic [OUT_W-1:0] s1;
        logic [OUT_W-1:0] s0;
    } dpc_pair_s;
endpackage : dpc_pkg

/* rtl/dpc_datapath.sv */
`timescale 1ns/1ps
// Contract
// [RULE_01] bit 6 of the third pattern register turns the output scrambler on, meant for 2-wire mode only.
// [RULE_02] the scrambler acts only while the dsp path is enabled, otherwise data leaves unscrambled.
// [RULE_03] a 20-bit frame pattern spans three registers (19:16, 15:8, 7:0) and resets to 0xffc00.
// [RULE_04] software picks the frame pattern from the table of output mode and resolution.
// [RULE_05] the averaging enable at dsp control bit 5 averages channels a and b, else it is bypassed.
// [RULE_06] the 2-bit input select routes a/b, a/a, b/b or average/average to the two converters.
// [RULE_07] the input select only counts while the input mux enable at decimation bit 7 is set.
// [RULE_08] dsp control bit 2 enables the dsp path and resets to disabled.
// [RULE_09] dsp control bit 1 enables both downconverters and resets to disabled.
// [RULE_10] decimation bits 6:4 select none, 2, 4, 8, 16 or 32; other codes are undefined.
// [RULE_11] decimation bit 3 selects complex (0) or real (1) mode for both converters.
// [RULE_12] each converter has a gain field where 00 adds nothing and 10 adds 6 dB.
// [RULE_13] toggling an oscillator reset bit clears that phase and loads the frequency word.
// [RULE_14] reserved bits are written as zero by software and kept at zero by the device.
module dpc_datapath
    import dpc_pkg::*;
#(
    parameter int unsigned SAMPLE_W = 18
) (
    input  wire logic                ref_clk_i,
    input  wire logic                rstn_i,
    input  wire logic [ADDR_W-1:0]   avs_address_i,
    input  wire logic                avs_read_i,
    input  wire logic                avs_write_i,
    input  wire logic [31:0]         avs_writedata_i,
    input  wire logic [3:0]          avs_byteenable_i,
    output logic      [31:0]         avs_readdata_o,
    output logic                     avs_waitrequest_o,
    input  wire logic [SAMPLE_W-1:0] chan_a_i,
    input  wire logic [SAMPLE_W-1:0] chan_b_i,
    input  wire logic                in_valid_i,
    output logic                     in_ready_o,
    input  wire logic [31:0]         frequency_word_0_i,
    input  wire logic [31:0]         frequency_word_1_i,
    output dpc_pair_s                out_data_o,
    output logic                     out_valid_o,
    input  wire logic                out_ready_i,
    output logic      [PAT_W-1:0]    frame_pattern_o,
    output logic                     real_complex_select_o,
    output logic      [31:0]         osc0_phase_o,
    output logic      [31:0]         osc1_phase_o
);
    if (SAMPLE_W < 2 || SAMPLE_W > OUT_W - 1) begin : g_chk
        $error("dpc_datapath: SAMPLE_W must lie in 2..19");
    end

    logic [7:0]  pat_low_q;
    logic [7:0]  pat_mid_q;
    logic [7:0]  pat_high_q;
    logic [7:0]  dsp_ctl_q;
    logic [7:0]  dec_ctl_q;
    logic [7:0]  gain_q;
    logic        ack_q;
    logic [31:0] rdata_q;
    logic [7:0]  rd_val;
    logic        hit;
    logic [5:0]  idx;
    logic        wr_en;

    // avalon slave: one wait cycle per access, traded for registered read data
    assign idx               = avs_address_i[7:2];
    assign hit               = (avs_address_i[1:0] == 2'h0);
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
    assign avs_readdata_o    = rdata_q;
    assign wr_en             = avs_write_i & ack_q & hit & avs_byteenable_i[0];

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
        end
    end

    always_comb begin
        rd_val = 8'h00;
        if (hit) begin
            unique case (idx)
                IDX_PAT_LOW:  rd_val = pat_low_q;
                IDX_PAT_MID:  rd_val = pat_mid_q;
                IDX_PAT_HIGH: rd_val = pat_high_q;
                IDX_DSP_CTL:  rd_val = dsp_ctl_q;
                IDX_DEC_CTL:  rd_val = dec_ctl_q;
                IDX_GAIN:     rd_val = gain_q;
                default:      rd_val = 8'h00;
            endcase
        end
    end

    // read data captured in the wait cycle so it stands at the releasing edge
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read_i && !ack_q) begin
            rdata_q <= {24'h00_0000, rd_val};
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pat_low_q  <= RST_PAT_LOW; // [RULE_03]
            pat_mid_q  <= RST_PAT_MID; // [RULE_03]
            pat_high_q <= RST_PAT_HIGH; // [RULE_03]
            dsp_ctl_q  <= RST_DSP_CTL; // [RULE_08] [RULE_09]
            dec_ctl_q  <= RST_DEC_CTL;
            gain_q     <= RST_GAIN;
        end else if (wr_en) begin
            unique case (idx)
                IDX_PAT_LOW:  pat_low_q  <= avs_writedata_i[7:0];
                IDX_PAT_MID:  pat_mid_q  <= avs_writedata_i[7:0];
                IDX_PAT_HIGH: pat_high_q <= avs_writedata_i[7:0] & MSK_PAT_HIGH; // [RULE_14]
                IDX_DSP_CTL:  dsp_ctl_q  <= avs_writedata_i[7:0] & MSK_DSP_CTL; // [RULE_14]
                IDX_DEC_CTL:  dec_ctl_q  <= avs_writedata_i[7:0] & MSK_DEC_CTL; // [RULE_14]
                IDX_GAIN:     gain_q     <= avs_writedata_i[7:0] & MSK_GAIN; // [RULE_14]
                default:      ;
            endcase
        end
    end

    // control fields
    logic       scrambler_enable;
    logic       averaging_enable;
    logic [1:0] downconverter_input_select;
    logic       dsp_enable;
    logic       downconverters_enable;
    logic       input_mux_enable;
    logic [2:0] decimation_ratio;
    logic       real_complex_select;
    logic [1:0] converter0_gain;
    logic [1:0] converter1_gain;

    assign scrambler_enable           = pat_high_q[POS_SCRAMBLE]; // [RULE_01]
    assign averaging_enable           = dsp_ctl_q[POS_AVERAGE]; // [RULE_05]
    assign downconverter_input_select = dsp_ctl_q[POS_INP_SEL +: 2];
    assign dsp_enable                 = dsp_ctl_q[POS_DSP_EN]; // [RULE_08]
    assign downconverters_enable      = dsp_ctl_q[POS_DC_EN]; // [RULE_09]
    assign input_mux_enable           = dec_ctl_q[POS_MUX_EN];
    assign decimation_ratio           = dec_ctl_q[POS_DEC_RAT +: 3];
    assign real_complex_select        = dec_ctl_q[POS_REAL]; // [RULE_11]
    assign converter0_gain            = gain_q[POS_GAIN0 +: 2];
    assign converter1_gain            = gain_q[POS_GAIN1 +: 2];

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            frame_pattern_o       <= {RST_PAT_HIGH[3:0], RST_PAT_MID, RST_PAT_LOW};
            real_complex_select_o <= 1'b0;
        end else begin
            frame_pattern_o       <= {pat_high_q[3:0], pat_mid_q, pat_low_q}; // [RULE_03]
            real_complex_select_o <= real_complex_select; // [RULE_11]
        end
    end

    // sample path
    logic signed [OUT_W-1:0] a_ext;
    logic signed [OUT_W-1:0] b_ext;
    logic signed [OUT_W:0]   sum;
    logic signed [OUT_W-1:0] avg_out;
    logic signed [OUT_W-1:0] dc0_in;
    logic signed [OUT_W-1:0] dc1_in;
    logic signed [OUT_W-1:0] dc0_g;
    logic signed [OUT_W-1:0] dc1_g;
    dpc_pair_s               word;
    logic                    take;
    logic                    push;
    logic                    fifo_full;
    logic [4:0]              dec_cnt_q;
    logic [4:0]              dec_last;
    logic [14:0]             lfsr_q;

    assign a_ext = OUT_W'($signed(chan_a_i));
    assign b_ext = OUT_W'($signed(chan_b_i));
    assign sum   = (OUT_W+1)'(a_ext) + (OUT_W+1)'(b_ext);
    // bypassed averager hands channel a through unchanged
    assign avg_out = averaging_enable ? sum[OUT_W:1] : a_ext; // [RULE_05]

    always_comb begin
        dc0_in = a_ext;
        dc1_in = b_ext;
        if (input_mux_enable) begin // [RULE_07]
            unique case (downconverter_input_select) // [RULE_06]
                2'h0: begin
                    dc0_in = a_ext;
                    dc1_in = b_ext;
                end
                2'h1: begin
                    dc0_in = a_ext;
                    dc1_in = a_ext;
                end
                2'h2: begin
                    dc0_in = b_ext;
                    dc1_in = b_ext;
                end
                2'h3: begin
                    dc0_in = avg_out;
                    dc1_in = avg_out;
                end
            endcase
        end
    end

    // 6 dB is a one-bit left shift; headroom comes from the spare output bit
    assign dc0_g = (converter0_gain == GAIN_6DB) ? (dc0_in <<< 1) : dc0_in; // [RULE_12]
    assign dc1_g = (converter1_gain == GAIN_6DB) ? (dc1_in <<< 1) : dc1_in; // [RULE_12]

    // undefined ratio codes fall back to no decimation
    assign dec_last = (decimation_ratio > DEC_MAX_CODE) ? 5'h00
                    : 5'((6'h01 << decimation_ratio) - 6'h01); // [RULE_10]

    always_comb begin
        if (!dsp_enable) begin
            word = {b_ext, a_ext}; // [RULE_02]
        end else begin
            word = {dc1_g, dc0_g};
            if (scrambler_enable) begin // [RULE_01] [RULE_02]
                word = word ^ {lfsr_q[4:0], lfsr_q, lfsr_q[4:0], lfsr_q};
            end
        end
    end

    assign in_ready_o = ~fifo_full;
    assign take       = in_valid_i & ~fifo_full;
    assign push       = take & (!dsp_enable || !downconverters_enable
                                || dec_cnt_q == dec_last); // [RULE_09] [RULE_10]

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dec_cnt_q <= 5'h00;
        end else if (!dsp_enable || !downconverters_enable) begin
            dec_cnt_q <= 5'h00;
        end else if (take) begin
            dec_cnt_q <= (dec_cnt_q >= dec_last) ? 5'h00 : dec_cnt_q + 5'h01; // [RULE_10]
        end
    end

    // x^15 + x^14 + 1 sequence, advanced once per scrambled output word
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lfsr_q <= SCR_SEED;
        end else if (push && dsp_enable && scrambler_enable) begin
            lfsr_q <= {lfsr_q[13:0], lfsr_q[14] ^ lfsr_q[13]};
        end
    end

    // oscillators
    logic [1:0]  osc_rst_prev_q;
    logic [1:0]  osc_rst_tgl;
    logic [31:0] fw0_q;
    logic [31:0] fw1_q;
    logic        osc_run;

    assign osc_rst_tgl = {gain_q[POS_OSC1_RST], gain_q[POS_OSC0_RST]} ^ osc_rst_prev_q; // [RULE_13]
    assign osc_run     = take & dsp_enable & downconverters_enable;

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            osc_rst_prev_q <= 2'h0;
        end else begin
            osc_rst_prev_q <= {gain_q[POS_OSC1_RST], gain_q[POS_OSC0_RST]};
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fw0_q        <= 32'h0000_0000;
            osc0_phase_o <= 32'h0000_0000;
        end else if (osc_rst_tgl[0]) begin
            fw0_q        <= frequency_word_0_i; // [RULE_13]
            osc0_phase_o <= 32'h0000_0000;
        end else if (osc_run) begin
            osc0_phase_o <= osc0_phase_o + fw0_q;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fw1_q        <= 32'h0000_0000;
            osc1_phase_o <= 32'h0000_0000;
        end else if (osc_rst_tgl[1]) begin
            fw1_q        <= frequency_word_1_i; // [RULE_13]
            osc1_phase_o <= 32'h0000_0000;
        end else if (osc_run) begin
            osc1_phase_o <= osc1_phase_o + fw1_q;
        end
    end

    // two-entry output buffer
    dpc_pair_s mem_q [2];
    logic      wr_ptr_q;
    logic      rd_ptr_q;
    logic [1:0] cnt_q;
    logic      pop;

    assign fifo_full   = (cnt_q == 2'h2);
    assign out_valid_o = (cnt_q != 2'h0);
    assign pop         = out_valid_o & out_ready_i;
    assign out_data_o  = mem_q[rd_ptr_q];

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end else if (push) begin
            mem_q[wr_ptr_q] <= word;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            cnt_q    <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 2'h1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 2'h1;
            end
        end
    end
endmodule : dpc_datapath

/* tb/dpc_sink.sv */
`timescale 1ns/1ps
module dpc_sink
    import dpc_pkg::*;
(
    input  wire logic      ref_clk_i,
    input  wire logic      rstn_i,
    input  wire dpc_pair_s data_i,
    input  wire logic      valid_i,
    input  wire logic      stall_i,
    output logic           ready_o
);
    dpc_pair_s got[$];
    // ready is registered, so a stall lands one cycle late, as in real capture logic
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ready_o <= 1'b0;
        end else begin
            ready_o <= !stall_i;
            if (valid_i && ready_o) begin
                got.push_back(data_i);
            end
        end
    end
endmodule : dpc_sink

/* tb/dpc_datapath_assertions.sv */
`timescale 1ns/1ps
module dpc_datapath_assertions
    import dpc_pkg::*;
(
    input wire logic              ref_clk_i,
    input wire logic              rstn_i,
    input wire logic              avs_read_i,
    input wire logic              avs_write_i,
    input wire logic [31:0]       avs_readdata_o,
    input wire logic              avs_waitrequest_o,
    input wire logic              in_valid_i,
    input wire logic              in_ready_o,
    input wire dpc_pair_s         out_data_o,
    input wire logic              out_valid_o,
    input wire logic              out_ready_i,
    input wire logic [PAT_W-1:0]  frame_pattern_o,
    input wire logic [31:0]       osc0_phase_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    wire req = avs_read_i || avs_write_i;
    chk_wait_one: assert property (req && !$past(req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("waitrequest not exactly one cycle");
    chk_idle_nowait: assert property (!req |-> !avs_waitrequest_o)
        else $error("waitrequest without request");
    chk_rdata_upper: assert property (avs_readdata_o[31:8] == 24'h0)
        else $error("readdata upper bits set");
    chk_frame_reset: assert property ($rose(rstn_i) |-> frame_pattern_o == 20'hffc00)
        else $error("frame pattern reset value");
    chk_frame_cause: assert property ($changed(frame_pattern_o) |-> $past(avs_write_i, 2))
        else $error("frame pattern changed without write");
    chk_out_hold: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
        else $error("output word lost during stall");
    chk_full_valid: assert property (!in_ready_o |-> out_valid_o)
        else $error("refusing input while empty");
    chk_valid_drop: assert property ($fell(out_valid_o) |-> $past(out_ready_i))
        else $error("output dropped without pop");
    chk_phase_cause: assert property ($changed(osc0_phase_o) |->
        $past(in_valid_i && in_ready_o) || $past(in_valid_i, 2)
        || $past(avs_write_i) || $past(avs_write_i, 2))
        else $error("phase moved without cause");
endmodule : dpc_datapath_assertions
bind dpc_datapath dpc_datapath_assertions dpc_datapath_assertions_i (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .in_valid_i(in_valid_i),
    .in_ready_o(in_ready_o), .out_data_o(out_data_o), .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i), .frame_pattern_o(frame_pattern_o),
    .osc0_phase_o(osc0_phase_o));

/* tb/dpc_datapath_bench.sv */
`timescale 1ns/1ps
module dpc_datapath_bench;
    import dpc_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic        wreq;
    logic [17:0] ca = 18'h0;
    logic [17:0] cb = 18'h0;
    logic        iv = 1'b0;
    logic        irdy;
    dpc_pair_s   od;
    logic        ov;
    logic        ordy;
    logic        stall = 1'b0;
    logic [19:0] fpat;
    logic        rcs;
    logic [31:0] ph0;
    logic [31:0] ph1;
    logic [7:0]  q;
    dpc_pair_s   w;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    logic [7:0]  ra [6] = '{8'h80, 8'h84, 8'h88, 8'h90, 8'h94, 8'h98};
    logic [7:0]  rr [6] = '{8'h00, 8'hfc, 8'h0f, 8'h00, 8'h00, 8'h00};
    logic [7:0]  mk [6] = '{8'hff, 8'hff, 8'h4f, 8'h3e, 8'hf8, 8'hee};
    logic [19:0] pt [5] = '{20'hfe000, 20'hff000, 20'hff800, 20'hffc00, 20'hfffff};
    logic [19:0] e0 [4] = '{20'h6, 20'h6, 20'h2, 20'h4};
    logic [19:0] e1 [4] = '{20'h2, 20'h6, 20'h2, 20'h4};
    always #4 clk = ~clk;
    dpc_datapath dpc_datapath_i (
        .ref_clk_i(clk), .rstn_i(rstn), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'h1),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .chan_a_i(ca), .chan_b_i(cb),
        .in_valid_i(iv), .in_ready_o(irdy), .frequency_word_0_i(32'h10),
        .frequency_word_1_i(32'h3), .out_data_o(od), .out_valid_o(ov), .out_ready_i(ordy),
        .frame_pattern_o(fpat), .real_complex_select_o(rcs), .osc0_phase_o(ph0),
        .osc1_phase_o(ph1));
    dpc_sink dpc_sink_i (.ref_clk_i(clk), .rstn_i(rstn), .data_i(od), .valid_i(ov),
        .stall_i(stall), .ready_o(ordy));
    task check(input string n, input logic [39:0] s, input logic [39:0] e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task bus(input logic w_, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= {24'h0, d};
        rd <= !w_;
        wr <= w_;
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task rchk(input string n, input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        check(n, q, e);
    endtask : rchk
    // leaves valid high so back-to-back samples need no extra cycle
    task put(input logic [17:0] a, input logic [17:0] b);
        ca <= a;
        cb <= b;
        iv <= 1'b1;
        do @(posedge clk); while (irdy !== 1'b1);
    endtask : put
    task pop();
        iv <= 1'b0;
        while (dpc_sink_i.got.size() == 0) @(posedge clk);
        w = dpc_sink_i.got.pop_front();
    endtask : pop
    task end_sim();
        if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_sim();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 6; i++) rchk("reset", ra[i], rr[i]);
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, ra[i], 8'hff);
            rchk("reserved", ra[i], mk[i]);
        end
        rchk("unmapped", 8'h8c, 8'h00);
        rchk("misaligned", 8'h81, 8'h00);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, 8'h80, pt[i][7:0]);
            bus(1'b1, 8'h84, pt[i][15:8]);
            bus(1'b1, 8'h88, {4'h0, pt[i][19:16]});
            repeat (2) @(posedge clk);
            check("pattern", fpat, pt[i]);
        end
        bus(1'b1, 8'h94, 8'h08);
        repeat (2) @(posedge clk);
        check("real", rcs, 1'b1);
        bus(1'b1, 8'h94, 8'h80);
        repeat (2) @(posedge clk);
        check("complex", rcs, 1'b0);
        bus(1'b1, 8'h98, 8'h00);
        bus(1'b1, 8'h90, 8'h00);
        bus(1'b1, 8'h88, 8'h4f);
        put(18'h5, 18'h3fffd);
        pop();
        check("raw", w, {20'hffffd, 20'h5});
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, 8'h90, {3'b001, s[1:0], 3'b100});
            bus(1'b1, 8'h88, 8'h0f);
            put(18'h6, 18'h2);
            pop();
            check("route", w, {e1[s], e0[s]});
        end
        // averager off with the average route selected passes channel a to both
        bus(1'b1, 8'h90, 8'h1c);
        put(18'h6, 18'h2);
        pop();
        check("avg off", w, {20'h6, 20'h6});
        bus(1'b1, 8'h94, 8'h00);
        bus(1'b1, 8'h90, 8'h0c);
        put(18'h6, 18'h2);
        pop();
        check("mux off", w, {20'h2, 20'h6});
        bus(1'b1, 8'h98, 8'h88);
        put(18'h6, 18'h2);
        pop();
        check("gain", w, {20'h4, 20'hc});
        bus(1'b1, 8'h98, 8'h00);
        bus(1'b1, 8'h88, 8'h4f);
        put(18'h6, 18'h2);
        pop();
        check("scramble", w.s0 == 20'h6, 1'b0);
        bus(1'b1, 8'h88, 8'h0f);
        bus(1'b1, 8'h90, 8'h06);
        bus(1'b1, 8'h98, 8'h20);
        repeat (2) @(posedge clk);
        check("phase clear", ph0, 32'h0);
        for (int c = 0; c < 6; c++) begin
            bus(1'b1, 8'h94, {1'b0, c[2:0], 4'h0});
            for (int n = 0; n < (2 << c); n++) put(18'h1, 18'h1);
            iv <= 1'b0;
            repeat (4) @(posedge clk);
            check("decimate", dpc_sink_i.got.size(), 2);
            dpc_sink_i.got.delete();
        end
        check("phase run", ph0, 32'h7e0);
        check("phase run 1", ph1, 32'h17a);
        // toggling back clears oscillator 0 only
        bus(1'b1, 8'h98, 8'h00);
        repeat (2) @(posedge clk);
        check("phase reload", ph0, 32'h0);
        check("phase keep 1", ph1, 32'h17a);
        bus(1'b1, 8'h90, 8'h00);
        stall <= 1'b1;
        put(18'h1, 18'h2);
        put(18'h3, 18'h4);
        repeat (3) @(posedge clk);
        check("full", irdy, 1'b0);
        iv <= 1'b0;
        stall <= 1'b0;
        repeat (4) @(posedge clk);
        check("drain", dpc_sink_i.got.size(), 2);
        pop();
        check("first", w, {20'h2, 20'h1});
        pop();
        check("second", w, {20'h4, 20'h3});
        check("empty", ov, 1'b0);
        end_sim();
    end
endmodule : dpc_datapath_bench
